// [start_guard.sv]
// start interlock: power-up start guard and supply switchover restart
//
// Contract
// RULE_01: guard off, run at power-up starts immediately
// RULE_02: function code 13 input enables guard
// RULE_03: guarded run at power-up trips, shows code
// RULE_04: run off or reset clears guard trip
// RULE_05: after run-off clear, start on new run
// RULE_06: reset clear with run active resumes immediately
// RULE_07: undervoltage trip reset still applies guard
// RULE_08: controller waits 3 s before asserting run
// RULE_09: switch function assignable to terminals 1-7
// RULE_10: switch release waits, matches frequency, accelerates
// RULE_11: low speed or fast decay starts 0 Hz
// RULE_12: operator lengthens delay after restart overcurrent
// RULE_13: any trip stops output, alarm at once
// RULE_14: retry delay programmable, zero means none
// RULE_15: run sampled once at power-up end
// RULE_16: guard clear drops alarm and code together
module start_guard
   import start_guard_pkg::*;
#(
   parameter int tick_period = tick_cycles
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [6:0] terminal_in,
   input wire logic [4:0] func_sel_0,
   input wire logic [4:0] func_sel_1,
   input wire logic [4:0] func_sel_2,
   input wire logic [4:0] func_sel_3,
   input wire logic [4:0] func_sel_4,
   input wire logic [4:0] func_sel_5,
   input wire logic [4:0] func_sel_6,
   input wire logic run_cmd,
   input wire logic fault_clear_input,
   input wire logic keypad_stop_reset,
   input wire logic power_up_done,
   input wire logic undervoltage,
   input wire logic [15:0] retry_delay_ms,
   input wire logic match_done,
   input wire logic speed_low,
   input wire logic fast_decay,
   output logic output_enable,
   output logic alarm,
   output logic [7:0] error_code,
   output logic freq_match,
   output logic start_zero_hz
);
   typedef struct packed {
      logic [6:0] term_s1;
      logic [6:0] term_s2;
      logic [4:0] ctl_s1;
      logic [4:0] ctl_s2;
      logic [1:0] sw_s;
      logic run_prev;
      logic switch_prev;
      logic clear_prev;
      logic cleared_by_run_off;
      logic [15:0] delay;
      state_t state;
      logic drive;
      logic alarm;
      logic [7:0] code;
      logic match;
      logic zero_hz;
   } sg_t;
   sg_t r, next_r;
   logic tick;
   logic [4:0] sel [terminal_count];
   logic guard_on, switch_on, run_s, clear_s, pup_s, uv_s;

   // return 1 when any synchronised terminal carries the given function
   function automatic logic func_active(input logic [6:0] t, input logic [4:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < terminal_count; i++) begin
         if (sel[i] == code && t[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   tick_divider #(.period(tick_period)) u_tick (
      .mclk(mclk),
      .nrst(nrst),
      .tick(tick)
   );

   always_comb begin
      sel[0] = func_sel_0;
      sel[1] = func_sel_1;
      sel[2] = func_sel_2;
      sel[3] = func_sel_3;
      sel[4] = func_sel_4;
      sel[5] = func_sel_5;
      sel[6] = func_sel_6;
   end

   // always_comb also wakes on sel, which the function reads from outside its arguments
   always_comb begin
      guard_on = func_active(r.term_s2, guard_func_code); // [RULE_02]
      switch_on = func_active(r.term_s2, switch_func_code); // [RULE_09]
   end
   assign run_s = r.ctl_s2[0];
   assign clear_s = r.ctl_s2[1];
   assign pup_s = r.ctl_s2[2];
   assign uv_s = r.ctl_s2[3];

   always_comb begin
      next_r = r;
      next_r.term_s1 = terminal_in;
      next_r.term_s2 = r.term_s1;
      next_r.ctl_s1 = {1'b0, undervoltage, power_up_done, fault_clear_input | keypad_stop_reset, run_cmd};
      next_r.ctl_s2 = r.ctl_s1;
      next_r.run_prev = run_s;
      next_r.switch_prev = switch_on;
      next_r.clear_prev = clear_s;
      case (r.state)
         st_power_up: begin
            if (pup_s) begin
               // single sample of run at end of power-up
               if (run_s && guard_on) begin // [RULE_15]
                  next_r.state = st_guard_trip; // [RULE_03]
                  next_r.alarm = 1'b1;
                  next_r.code = guard_fault_code;
               end else if (run_s) begin
                  next_r.state = st_run; // [RULE_01]
                  next_r.drive = 1'b1;
               end else begin
                  next_r.state = st_stop;
               end
            end
         end
         st_stop: begin
            // level run only restarts when not waiting for a fresh edge
            if (run_s && (!r.cleared_by_run_off || !r.run_prev)) begin // [RULE_05]
               next_r.state = st_run;
               next_r.drive = 1'b1;
               next_r.cleared_by_run_off = 1'b0;
            end else if (!run_s) begin
               next_r.cleared_by_run_off = 1'b0;
            end
         end
         st_run: begin
            if (!run_s) begin
               next_r.state = st_stop;
               next_r.drive = 1'b0;
            end else if (switch_on) begin
               // supply handed to utility; output off while held
               next_r.drive = 1'b0;
            end else if (r.switch_prev) begin
               next_r.drive = 1'b0;
               next_r.delay = retry_delay_ms;
               next_r.state = (retry_delay_ms == delay_reset) ? st_match : st_coast_wait; // [RULE_14]
            end
         end
         st_coast_wait: begin
            if (!run_s) begin
               next_r.state = st_stop;
            end else if (r.delay == delay_reset) begin
               next_r.state = st_match; // [RULE_10]
            end else if (tick) begin
               next_r.delay = r.delay - 16'h0001;
            end
         end
         st_match: begin
            next_r.match = 1'b1;
            next_r.zero_hz = speed_low | fast_decay; // [RULE_11]
            if (!run_s) begin
               next_r.state = st_stop;
               next_r.match = 1'b0;
               next_r.zero_hz = 1'b0;
            end else if (match_done || speed_low || fast_decay) begin
               next_r.state = st_run; // [RULE_10]
               next_r.drive = 1'b1;
               next_r.match = 1'b0;
            end
         end
         st_guard_trip: begin
            if (clear_s && !r.clear_prev) begin
               // reset with run still on resumes at once
               next_r.state = run_s ? st_run : st_stop; // [RULE_06]
               next_r.drive = run_s;
               next_r.alarm = 1'b0; // [RULE_16]
               next_r.code = no_fault_code;
            end else if (!run_s) begin
               next_r.state = st_stop; // [RULE_04]
               next_r.cleared_by_run_off = 1'b1;
               next_r.alarm = 1'b0; // [RULE_16]
               next_r.code = no_fault_code;
            end
         end
         st_uv_trip: begin
            // trip clears on reset release, then guard check reapplies
            if (!clear_s && r.clear_prev) begin
               next_r.alarm = 1'b0;
               next_r.code = no_fault_code;
               next_r.state = st_power_up; // [RULE_07]
            end
         end
         default: begin
            next_r.state = st_power_up;
         end
      endcase
      if (uv_s && r.state != st_uv_trip && r.state != st_power_up) begin
         next_r.state = st_uv_trip; // [RULE_13]
         next_r.drive = 1'b0;
         next_r.match = 1'b0;
         next_r.zero_hz = 1'b0;
         next_r.alarm = 1'b1;
         next_r.code = undervoltage_fault_code;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // trips drop drive in the same cycle they are entered
   assign output_enable = r.drive; // [RULE_13]
   assign alarm = r.alarm;
   assign error_code = r.code;
   assign freq_match = r.match;
   assign start_zero_hz = r.zero_hz;
endmodule

// [start_guard_pkg.sv]
// shared constants and types for the start guard and supply switch block
package start_guard_pkg;
   localparam int clk_hz = 100_000_000;
   localparam int clk_ns = 10;
   localparam logic [4:0] guard_func_code = 5'h0D;
   localparam logic [4:0] switch_func_code = 5'h0E;
   localparam int first_terminal = 1;
   localparam int terminal_count = 7;
   localparam int tick_ms = 1;
   localparam int tick_cycles = tick_ms * (clk_hz / 1000);
   localparam int min_run_wait_s = 3;
   localparam logic [7:0] guard_fault_code = 8'h0D;
   localparam logic [7:0] undervoltage_fault_code = 8'h09;
   localparam logic [7:0] no_fault_code = 8'h00;
   localparam logic [15:0] delay_reset = 16'h0000;
   localparam logic [19:0] tick_reset = 20'h00000;
   typedef enum {st_power_up, st_stop, st_run, st_guard_trip, st_uv_trip,
                 st_coast_wait, st_match} state_t;
endpackage

// [tick_divider.sv]
// divider producing a one-cycle enable pulse every tick period
module tick_divider
   import start_guard_pkg::*;
#(
   parameter int period = tick_cycles
) (
   input wire logic mclk,
   input wire logic nrst,
   output logic tick
);
   typedef struct packed {
      logic [19:0] count;
      logic pulse;
   } div_t;
   div_t r, next_r;

   always_comb begin
      next_r = r;
      next_r.pulse = 1'b0;
      if (r.count == 20'(period - 1)) begin
         next_r.count = tick_reset;
         next_r.pulse = 1'b1;
      end else begin
         next_r.count = r.count + 20'h00001;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign tick = r.pulse;
endmodule

// [start_guard_assertions.sv]
// concurrent checks on the start guard ports
module start_guard_checker
   import start_guard_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic run_cmd,
   input wire logic speed_low,
   input wire logic fast_decay,
   input wire logic output_enable,
   input wire logic alarm,
   input wire logic [7:0] error_code,
   input wire logic freq_match,
   input wire logic start_zero_hz
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   alarm_code_a: assert property (alarm == (error_code != no_fault_code))
      else $error("alarm and code disagree");
   trip_off_a: assert property (alarm |-> !output_enable)
      else $error("drive during trip");
   match_off_a: assert property (freq_match |-> !output_enable)
      else $error("drive while matching");
   zero_hz_a: assert property ($rose(freq_match) |-> start_zero_hz == (speed_low | fast_decay))
      else $error("wrong restart point");
   zero_start_a: assert property ($rose(start_zero_hz) |-> $past(speed_low) || $past(fast_decay))
      else $error("zero start without cause");
   clear_code_a: assert property ($fell(alarm) |-> error_code == no_fault_code)
      else $error("code left after clear");
   // input sync plus one register gives the margin
   run_drop_a: assert property (!run_cmd [*5] |-> error_code != guard_fault_code)
      else $error("guard trip not cleared");
   run_cause_a: assert property ($rose(output_enable) |-> $past(run_cmd, 2))
      else $error("start without run");
   guard_src_a: assert property ($rose(alarm) && error_code == guard_fault_code |-> $past(run_cmd, 2))
      else $error("guard trip without run");
endmodule
bind start_guard start_guard_checker u_chk (.mclk, .nrst, .run_cmd, .speed_low, .fast_decay,
   .output_enable, .alarm, .error_code, .freq_match, .start_zero_hz);

// [motor_partner.sv]
// coasting motor model: reports the frequency search done after a lag
module motor_partner
   import start_guard_pkg::*;
#(
   parameter int lag = 60
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic freq_match,
   output logic match_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // a slow answer keeps the matching window visible at the ports
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
      end else begin
         cnt <= freq_match ? cnt + 1 : 0;
      end
   end
   assign match_done = freq_match && cnt >= lag;
endmodule

// [tb_top.sv]
// self-checking bench for the start guard block
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top
   import start_guard_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, nrst = 0, run_cmd = 0, fci = 0, kps = 0, pud = 0, uv = 0, sl = 0, fd = 0;
   logic [6:0] term = '0;
   logic [4:0] fs [7] = '{guard_func_code, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
   logic [15:0] rd = '0;
   logic md, oe, al, fm, sz;
   logic [7:0] ec;
   int n_fail = 0, total_checks = 0;
   always #5 mclk = ~mclk;
   start_guard #(.tick_period(10)) u_dut (.mclk, .nrst, .terminal_in(term), .func_sel_0(fs[0]),
      .func_sel_1(fs[1]), .func_sel_2(fs[2]), .func_sel_3(fs[3]), .func_sel_4(fs[4]),
      .func_sel_5(fs[5]), .func_sel_6(fs[6]), .run_cmd, .fault_clear_input(fci),
      .keypad_stop_reset(kps), .power_up_done(pud), .undervoltage(uv), .retry_delay_ms(rd),
      .match_done(md), .speed_low(sl), .fast_decay(fd), .output_enable(oe), .alarm(al),
      .error_code(ec), .freq_match(fm), .start_zero_hz(sz));
   motor_partner #(.lag(60)) u_motor (.mclk, .nrst, .freq_match(fm), .match_done(md));
   task automatic wt(int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic pwr(logic g, logic r);
      wt(1);
      nrst <= 1'b0;
      pud <= 1'b0;
      run_cmd <= r;
      term <= {6'h00, g};
      wt(16);
      nrst <= 1'b1;
      wt(2);
      pud <= 1'b1;
      wt(8);
   endtask
   task automatic complete_run();
      if (n_fail == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      pwr(1'b0, 1'b1);
      `CHK("run at power-up", 1'b1, oe)
      pwr(1'b1, 1'b1);
      `CHK("guard code", guard_fault_code, ec)
      `CHK("guard alarm", 1'b1, al)
      `CHK("guard hold", 1'b0, oe)
      run_cmd <= 1'b0;
      wt(6);
      `CHK("clear code", no_fault_code, ec)
      `CHK("clear alarm", 1'b0, al)
      `CHK("no restart", 1'b0, oe)
      run_cmd <= 1'b1;
      wt(6);
      `CHK("fresh run", 1'b1, oe)
      for (int k = 0; k < 2; k++) begin
         pwr(1'b1, 1'b1);
         fci <= (k == 0);
         kps <= (k == 1);
         wt(6);
         fci <= 1'b0;
         kps <= 1'b0;
         wt(6);
         `CHK("reset clear", no_fault_code, ec)
         `CHK("resume", 1'b1, oe)
      end
      pwr(1'b1, 1'b0);
      `CHK("no trip", 1'b0, al)
      run_cmd <= 1'b1;
      wt(6);
      `CHK("late run", 1'b1, oe)
      uv <= 1'b1;
      wt(6);
      `CHK("uv code", undervoltage_fault_code, ec)
      `CHK("uv stop", 1'b0, oe)
      uv <= 1'b0;
      fci <= 1'b1;
      wt(6);
      fci <= 1'b0;
      wt(6);
      `CHK("guard after uv", guard_fault_code, ec)
      for (int t = 0; t < 7; t++) begin
         fs[t] <= switch_func_code;
         sl <= t[0];
         fd <= (t == 6);
         rd <= t[1] ? 16'h0003 : 16'h0000;
         pwr(1'b0, 1'b1);
         term[t] <= 1'b1;
         wt(6);
         `CHK("switch off", 1'b0, oe)
         term[t] <= 1'b0;
         wt(15);
         // a slow or fast-decaying motor skips the search and restarts from zero
         `CHK("retry wait", !t[1] && !(t[0] || t == 6), fm)
         wt(40);
         `CHK("matching", !(t[0] || t == 6), fm)
         `CHK("zero start", t[0] | (t == 6), sz)
         wt(80);
         `CHK("resumed", 1'b1, oe)
         fs[t] <= 5'h00;
      end
      complete_run();
   end
   // the whole sequence needs about 14 us, under a tenth of this
   initial begin
      #200us;
      n_fail++;
      complete_run();
   end
endmodule
